// ### hw/mfpr_top.sv
// What this block does
// R1 - output 4 is driven from level bit 4 when a terminal routes it
// R2 - level bits 3..0 drive general outputs 3..0; read and write
// R3 - level bits 7..5 read zero; writes to them change nothing
// R4 - levels cleared and routing fields set to their reset value only by global reset
// R5 - routing register holds seven 4-bit fields; bits 31..28 read zero
// R6 - terminal 6: clock-run, IRQ2, IRQ4..IRQ15; 0000 reserved
// R7 - terminal 5: input 4, output 4, grant, IRQs, PWM, LEDs, event
// R8 - terminal 4: input 3, output 3, lock, IRQs, INTD, ring, LED, event
// R9 - terminal 3: serialized interrupt, IRQ2, IRQ4..IRQ15; resets to 0001
// R10 - terminal 2: input 2, output 2, request, IRQs, INTC, ring, test_observe_mux
// R11 - terminal 1: input 1, activity LEDs, event output, IRQ15
// R12 - terminal 0: input 0, PWM, IRQ9..11, activity LEDs, event, IRQ15
// R13 - routing value can be loaded from serial configuration memory at init
// R14 - software programs the routing once during power-on initialization
// R15 - level change on a terminal routed as input sets its event status
// R16 - input-level register shows inputs 4..0 from their routed terminals
// R17 - reserved selection codes leave the terminal undriven
// R18 - input selections never enable the terminal driver
`timescale 1ns/1ps
module mfpr_top import mfpr_pkg::*; (
   // clock and global reset
   input wire logic clk,
   input wire logic arst_n,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // routing value from the serial configuration loader
   input wire logic cfg_load_valid,
   input wire logic [31:0] cfg_load_data,
   // internal functions to route out
   input wire mfpr_src_type src,
   // multifunction terminals, split pins
   input wire logic [NUM_TERM-1:0] term_in,
   output logic [NUM_TERM-1:0] term_out,
   output logic [NUM_TERM-1:0] term_oe_n,
   // inputs taken from terminals and event signalling
   output logic card_bus_grant,
   output logic pci_lock,
   output logic event_output
);
   mfpr_state_type st_r;
   mfpr_state_type st_nxt;
   logic [NUM_TERM-1:0] term_level;

   // pins come from outside, so each passes three stages
   mfpr_pin_sync #(.W(NUM_TERM)) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .pin_async(term_in),
      .level(term_level)
   );

   // each general input must name a real terminal
   for (genvar g = 0; g < NUM_GP; g++) begin : g_map_chk
      if (GPI_TERM_MAP[3*g +: 3] >= NUM_TERM) begin : g_bad
         $error("general input mapped past the last terminal");
      end
   end

   // register read view; reserved bits return zero
   function automatic logic [DATA_W-1:0] read_view(input mfpr_state_type s,
                                                   input logic [7:0] idx);
      logic [DATA_W-1:0] v;
      v = '0;
      unique case (idx)
         EVT_STATUS_IDX: v[NUM_GP-1:0] = s.evt_status;
         EVT_ENABLE_IDX: v[NUM_GP-1:0] = s.evt_enable;
         GPI_LEVELS_IDX: v[NUM_GP-1:0] = s.gpi_levels; // R16
         GPO_LEVELS_IDX: v[NUM_GP-1:0] = s.gpo_levels; // R3
         ROUTE_IDX: v = s.route & ROUTE_MASK; // R5
         default: v = '0;
      endcase
      return v;
   endfunction : read_view

   always_comb begin
      logic req;
      logic done;
      logic [7:0] idx;
      logic [31:0] rt;
      logic [3:0] sel;
      logic [NUM_GP-1:0] routed_in;
      logic [NUM_GP-1:0] cur;
      logic [NUM_GP-1:0] changed;
      logic [NUM_GP-1:0] clr;
      logic [2:0] t;
      req = 1'b0;
      done = 1'b0;
      idx = '0;
      rt = '0;
      sel = '0;
      routed_in = '0;
      cur = '0;
      changed = '0;
      clr = '0;
      t = '0;
      st_nxt = st_r;

      // handshake: one wait cycle, then the request completes
      // read data is captured in the wait cycle so it stands while waitrequest is low
      req = avs_read | avs_write;
      done = req & ~st_r.waitreq;
      idx = avs_address[ADDR_W-1:IDX_LSB];
      st_nxt.waitreq = ~(req & st_r.waitreq);
      if (req && st_r.waitreq && avs_read) begin
         st_nxt.rdata = read_view(st_r, idx);
      end

      // register writes take effect on the completing edge
      if (done && avs_write) begin
         unique case (idx)
            EVT_STATUS_IDX: begin
               if (avs_byteenable[0]) begin
                  clr = avs_writedata[NUM_GP-1:0];
               end
            end
            EVT_ENABLE_IDX: begin
               if (avs_byteenable[0]) begin
                  st_nxt.evt_enable = avs_writedata[NUM_GP-1:0];
               end
            end
            GPO_LEVELS_IDX: begin
               if (avs_byteenable[0]) begin
                  st_nxt.gpo_levels = avs_writedata[NUM_GP-1:0]; // R2 R3
               end
            end
            ROUTE_IDX: begin
               rt = st_r.route;
               for (int b = 0; b < 4; b++) begin
                  if (avs_byteenable[b]) begin
                     rt[8*b +: 8] = avs_writedata[8*b +: 8];
                  end
               end
               st_nxt.route = rt & ROUTE_MASK; // R5
            end
            default: begin
            end
         endcase
      end

      // loader wins over a bus write in the same cycle; it loads in any cycle that cfg_load_valid is high
      if (cfg_load_valid) begin
         st_nxt.route = cfg_load_data & ROUTE_MASK; // R13
      end

      // general inputs: level and change detect per input
      for (int g = 0; g < NUM_GP; g++) begin
         t = GPI_TERM_MAP[3*g +: 3];
         routed_in[g] = (st_r.route[SEL_W*t +: SEL_W] == SEL_GPI);
         cur[g] = term_level[t];
         changed[g] = routed_in[g] & (cur[g] != st_r.gpi_prev[g]); // R15
      end
      st_nxt.gpi_prev = cur;
      st_nxt.gpi_levels = cur & routed_in; // R16
      // a change in the clearing cycle still sets the flag
      st_nxt.evt_status = (st_r.evt_status & ~clr) | changed; // R15
      st_nxt.event_output = |(st_r.evt_status & st_r.evt_enable);

      // input functions delivered inward; idle high when not routed
      // they follow the filtered pin, so they lag the terminal by five edges
      st_nxt.card_bus_grant = (st_r.route[23:20] == SEL_ALT) ? term_level[5] : 1'b1;
      st_nxt.pci_lock = (st_r.route[19:16] == SEL_ALT) ? term_level[4] : 1'b1;

      // default: every terminal undriven, low value
      st_nxt.term_out = '0;
      st_nxt.term_oe_n = '1; // R17 R18

      // terminal 6
      sel = st_r.route[27:24];
      if (sel == SEL_GPO) begin
         st_nxt.term_out[6] = src.clock_run; // R6
         st_nxt.term_oe_n[6] = 1'b0;
      end else if (sel == SEL_ALT || sel >= SEL_IRQ4) begin
         st_nxt.term_out[6] = src.irq[sel]; // R6
         st_nxt.term_oe_n[6] = 1'b0;
      end

      // terminal 3
      sel = st_r.route[15:12];
      if (sel == SEL_GPO) begin
         st_nxt.term_out[3] = src.serialized_interrupt; // R9
         st_nxt.term_oe_n[3] = 1'b0;
      end else if (sel == SEL_ALT || sel >= SEL_IRQ4) begin
         st_nxt.term_out[3] = src.irq[sel]; // R9
         st_nxt.term_oe_n[3] = 1'b0;
      end

      // terminal 5
      st_nxt.term_oe_n[5] = 1'b0;
      unique case (st_r.route[23:20])
         SEL_GPO: st_nxt.term_out[5] = st_r.gpo_levels[4]; // R1
         SEL_IRQ4: st_nxt.term_out[5] = src.irq[4]; // R7
         SEL_IRQ5: st_nxt.term_out[5] = src.irq[5];
         SEL_PWM: st_nxt.term_out[5] = src.card_audio_pwm;
         SEL_IRQ9: st_nxt.term_out[5] = src.irq[9];
         SEL_A: st_nxt.term_out[5] = src.irq[10];
         SEL_B: st_nxt.term_out[5] = src.link_activity_led;
         SEL_C: st_nxt.term_out[5] = src.activity_led_1;
         SEL_D: st_nxt.term_out[5] = src.socket_led;
         SEL_EVT: st_nxt.term_out[5] = st_r.event_output;
         SEL_F: st_nxt.term_out[5] = src.irq[15];
         default: st_nxt.term_oe_n[5] = 1'b1; // R17 R18
      endcase

      // terminal 4
      st_nxt.term_oe_n[4] = 1'b0;
      unique case (st_r.route[19:16])
         SEL_GPO: st_nxt.term_out[4] = st_r.gpo_levels[3]; // R2
         SEL_IRQ4: st_nxt.term_out[4] = src.irq[4]; // R8
         SEL_IRQ5: st_nxt.term_out[4] = src.irq[5];
         SEL_PWM: st_nxt.term_out[4] = src.card_audio_pwm;
         SEL_IRQ9: st_nxt.term_out[4] = src.irq[9];
         SEL_A: st_nxt.term_out[4] = src.intd;
         SEL_B: st_nxt.term_out[4] = src.irq[11];
         SEL_C: st_nxt.term_out[4] = src.ring_out;
         SEL_D: st_nxt.term_out[4] = src.socket_led;
         SEL_EVT: st_nxt.term_out[4] = st_r.event_output;
         SEL_F: st_nxt.term_out[4] = src.irq[15];
         default: st_nxt.term_oe_n[4] = 1'b1; // R17 R18
      endcase

      // terminal 2
      st_nxt.term_oe_n[2] = 1'b0;
      unique case (st_r.route[11:8])
         SEL_GPO: st_nxt.term_out[2] = st_r.gpo_levels[2]; // R2
         SEL_ALT: st_nxt.term_out[2] = src.card_bus_request; // R10
         SEL_IRQ4: st_nxt.term_out[2] = src.irq[4];
         SEL_IRQ5: st_nxt.term_out[2] = src.irq[5];
         SEL_PWM: st_nxt.term_out[2] = src.card_audio_pwm;
         SEL_IRQ9: st_nxt.term_out[2] = src.irq[9];
         SEL_A: st_nxt.term_out[2] = src.irq[10];
         SEL_B: st_nxt.term_out[2] = src.intc;
         SEL_C: st_nxt.term_out[2] = src.ring_out;
         SEL_D: st_nxt.term_out[2] = src.test_observe_mux;
         SEL_EVT: st_nxt.term_out[2] = st_r.event_output;
         SEL_F: st_nxt.term_out[2] = src.irq[7];
         default: st_nxt.term_oe_n[2] = 1'b1; // R17 R18
      endcase

      // terminal 1
      st_nxt.term_oe_n[1] = 1'b0;
      unique case (st_r.route[7:4])
         SEL_GPO: st_nxt.term_out[1] = st_r.gpo_levels[1]; // R2
         SEL_C: st_nxt.term_out[1] = src.activity_led_1; // R11
         SEL_D: st_nxt.term_out[1] = src.activity_led_2;
         SEL_EVT: st_nxt.term_out[1] = st_r.event_output;
         SEL_F: st_nxt.term_out[1] = src.irq[15];
         default: st_nxt.term_oe_n[1] = 1'b1; // R17 R18
      endcase

      // terminal 0
      st_nxt.term_oe_n[0] = 1'b0;
      unique case (st_r.route[3:0])
         SEL_GPO: st_nxt.term_out[0] = st_r.gpo_levels[0]; // R2
         SEL_PWM: st_nxt.term_out[0] = src.card_audio_pwm; // R12
         SEL_IRQ9: st_nxt.term_out[0] = src.irq[9];
         SEL_A: st_nxt.term_out[0] = src.irq[10];
         SEL_B: st_nxt.term_out[0] = src.irq[11];
         SEL_C: st_nxt.term_out[0] = src.activity_led_1;
         SEL_D: st_nxt.term_out[0] = src.activity_led_2;
         SEL_EVT: st_nxt.term_out[0] = st_r.event_output;
         SEL_F: st_nxt.term_out[0] = src.irq[15];
         default: st_nxt.term_oe_n[0] = 1'b1; // R17 R18
      endcase
   end

   // only the global reset clears this state; there is no soft reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0; // R4
         // pins idle high through the board pull-ups; the edge detector starts
         // there too, so leaving reset does not raise a false input event
         st_r.gpi_prev <= '1; // R15
         st_r.gpo_levels <= GPO_RESET;
         st_r.route <= ROUTE_RESET; // R9
         st_r.evt_status <= EVT_RESET;
         st_r.evt_enable <= EVT_RESET;
         st_r.term_oe_n <= '1;
         st_r.card_bus_grant <= 1'b1;
         st_r.pci_lock <= 1'b1;
         st_r.waitreq <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // every output is a state flop
   assign avs_readdata = st_r.rdata;
   assign avs_waitrequest = st_r.waitreq;
   assign term_out = st_r.term_out;
   assign term_oe_n = st_r.term_oe_n;
   assign card_bus_grant = st_r.card_bus_grant;
   assign pci_lock = st_r.pci_lock;
   assign event_output = st_r.event_output;

endmodule : mfpr_top

// ### hw/mfpr_pkg.sv
package mfpr_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] EVT_STATUS_IDX = 8'h88;
   localparam logic [7:0] EVT_ENABLE_IDX = 8'h89;
   localparam logic [7:0] GPI_LEVELS_IDX = 8'h8a;
   localparam logic [7:0] GPO_LEVELS_IDX = 8'h8b;
   localparam logic [7:0] ROUTE_IDX = 8'h8c;

   // bus geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int IDX_LSB = 2;

   // counts of terminals and general-purpose lines
   localparam int NUM_TERM = 7;
   localparam int NUM_GP = 5;
   localparam int SEL_W = 4;

   // reset values and writable masks
   localparam logic [NUM_GP-1:0] GPO_RESET = 5'h00;
   localparam logic [NUM_GP-1:0] EVT_RESET = 5'h00;
   localparam logic [31:0] ROUTE_RESET = 32'h0000_1000;
   localparam logic [31:0] ROUTE_MASK = 32'h0fff_ffff;

   // terminal carrying each general input: 0,1,2,4,5 for inputs 0..4
   localparam logic [14:0] GPI_TERM_MAP = {3'h5, 3'h4, 3'h2, 3'h1, 3'h0};

   // selection codes
   localparam logic [3:0] SEL_GPI = 4'h0;
   localparam logic [3:0] SEL_GPO = 4'h1;
   localparam logic [3:0] SEL_ALT = 4'h2;
   localparam logic [3:0] SEL_IRQ4 = 4'h4;
   localparam logic [3:0] SEL_IRQ5 = 4'h5;
   localparam logic [3:0] SEL_PWM = 4'h8;
   localparam logic [3:0] SEL_IRQ9 = 4'h9;
   localparam logic [3:0] SEL_A = 4'ha;
   localparam logic [3:0] SEL_B = 4'hb;
   localparam logic [3:0] SEL_C = 4'hc;
   localparam logic [3:0] SEL_D = 4'hd;
   localparam logic [3:0] SEL_EVT = 4'he;
   localparam logic [3:0] SEL_F = 4'hf;

   // internal functions that can be routed out
   typedef struct packed {
      logic [15:0] irq;
      logic clock_run;
      logic serialized_interrupt;
      logic card_bus_request;
      logic card_audio_pwm;
      logic link_activity_led;
      logic activity_led_1;
      logic activity_led_2;
      logic socket_led;
      logic ring_out;
      logic test_observe_mux;
      logic intc;
      logic intd;
   } mfpr_src_type;

   // whole state of the routing block
   typedef struct packed {
      logic [NUM_GP-1:0] gpo_levels;
      logic [31:0] route;
      logic [NUM_GP-1:0] evt_status;
      logic [NUM_GP-1:0] evt_enable;
      logic [NUM_GP-1:0] gpi_prev;
      logic [NUM_GP-1:0] gpi_levels;
      logic [NUM_TERM-1:0] term_out;
      logic [NUM_TERM-1:0] term_oe_n;
      logic event_output;
      logic card_bus_grant;
      logic pci_lock;
      logic waitreq;
      logic [DATA_W-1:0] rdata;
   } mfpr_state_type;

endpackage : mfpr_pkg

// ### hw/mfpr_pin_sync.sv
`timescale 1ns/1ps
module mfpr_pin_sync import mfpr_pkg::*; #(
   parameter int W = 7
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // raw pins and filtered levels
   input wire logic [W-1:0] pin_async,
   output logic [W-1:0] level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } mfpr_sync_state_type;

   mfpr_sync_state_type st_r;
   mfpr_sync_state_type st_nxt;

   if (W < 1) begin : g_chk
      $error("mfpr_pin_sync needs at least one bit");
   end

   // three stages; a level only counts once stages two and three agree
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = pin_async;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < W; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.lvl[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '1; // start at the pull-up level so no edge follows reset
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level = st_r.lvl;

endmodule : mfpr_pin_sync

// ### tb/mfpr_chk.sv
`timescale 1ns/1ps
module mfpr_chk import mfpr_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // register bus
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   // loader, sources, terminals
   input wire logic cfg_load_valid,
   input wire logic [31:0] cfg_load_data,
   input wire mfpr_src_type src,
   input wire logic [NUM_TERM-1:0] term_out,
   input wire logic [NUM_TERM-1:0] term_oe_n
);
   logic [31:0] route_r;
   logic [NUM_GP-1:0] gpo_r;
   logic wr_ok;
   logic rd_ok;
   logic irq6_pick;
   logic irq3_pick;
   // completed transfers and the irq line each field selects
   assign wr_ok = avs_write && !avs_waitrequest;
   assign rd_ok = avs_read && !avs_waitrequest;
   assign irq6_pick = src.irq[route_r[27:24]];
   assign irq3_pick = src.irq[route_r[15:12]];
   // shadow registers; the loader beats a bus write in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         route_r <= ROUTE_RESET;
         gpo_r <= GPO_RESET;
      end else begin
         if (cfg_load_valid) begin
            route_r <= cfg_load_data & ROUTE_MASK;
         end else if (wr_ok && avs_address[9:2] == ROUTE_IDX) begin
            for (int i = 0; i < 4; i++) begin
               if (avs_byteenable[i]) begin
                  route_r[8*i +: 8] <= avs_writedata[8*i +: 8] & ROUTE_MASK[8*i +: 8];
               end
            end
         end
         // the loader only beats a routing write; level writes still land
         if (wr_ok && avs_address[9:2] == GPO_LEVELS_IDX && avs_byteenable[0]) begin
            gpo_r <= avs_writedata[NUM_GP-1:0];
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // a pending request gets exactly one cycle of answer
   sequence s_pending;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_wait_answer: assert property (s_pending |=> s_answer)
      else $error("request not answered in one cycle");
   a_reset_drive: assert property ($rose(arst_n) |=> term_oe_n == 7'h77)
      else $error("wrong terminal drive after reset");
   a_route_read: assert property (rd_ok && avs_address[9:2] == ROUTE_IDX |->
      avs_readdata == route_r) else $error("routing readback wrong");
   a_gpo_read: assert property (rd_ok && avs_address[9:2] == GPO_LEVELS_IDX |->
      avs_readdata == 32'(gpo_r)) else $error("output level readback wrong");
   // the terminal follows its register one edge later
   a_out4_level: assert property (route_r[23:20] == SEL_GPO |=>
      !term_oe_n[5] && term_out[5] == $past(gpo_r[4])) else $error("output 4 wrong");
   a_out3_level: assert property (route_r[19:16] == SEL_GPO |=>
      !term_oe_n[4] && term_out[4] == $past(gpo_r[3])) else $error("output 3 wrong");
   a_term6_irq: assert property (route_r[27:24] >= SEL_IRQ4 |=>
      !term_oe_n[6] && term_out[6] == $past(irq6_pick)) else $error("terminal 6 irq wrong");
   a_term3_irq: assert property (route_r[15:12] >= SEL_IRQ4 |=>
      !term_oe_n[3] && term_out[3] == $past(irq3_pick)) else $error("terminal 3 irq wrong");
   a_input_quiet: assert property (route_r[11:8] == SEL_GPI |=> term_oe_n[2])
      else $error("input terminal driven");
   a_reserved_quiet: assert property (route_r[23:20] == 4'h3 |=> term_oe_n[5])
      else $error("reserved code drives terminal");
endmodule : mfpr_chk

bind mfpr_top mfpr_chk i_chk (.clk, .arst_n, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cfg_load_valid,
   .cfg_load_data, .src, .term_out, .term_oe_n);

// ### tb/mfpr_board.sv
`timescale 1ns/1ps
module mfpr_board import mfpr_pkg::*; (
   // device side of the terminals
   input wire logic [NUM_TERM-1:0] term_out,
   input wire logic [NUM_TERM-1:0] term_oe_n,
   // board drivers as the bench commands them
   input wire logic [NUM_TERM-1:0] board_drv,
   input wire logic [NUM_TERM-1:0] board_oe,
   // resolved terminal levels
   output logic [NUM_TERM-1:0] term_in
);
   // pull-up on every terminal; two drivers at once give an unknown level
   always_comb begin
      for (int i = 0; i < NUM_TERM; i++) begin
         term_in[i] = !term_oe_n[i] ? (board_oe[i] ? 1'bx : term_out[i]) :
            (board_oe[i] ? board_drv[i] : 1'b1);
      end
   end
endmodule : mfpr_board

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench import mfpr_pkg::*;;
   // bus master, loader, sources and board drivers
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [ADDR_W-1:0] avs_address = 10'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic cfg_load_valid = 1'b0;
   logic [31:0] cfg_load_data = 32'h0;
   mfpr_src_type src = '0;
   logic [NUM_TERM-1:0] board_drv = 7'h00;
   logic [NUM_TERM-1:0] board_oe = 7'h00;
   // design outputs
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic [NUM_TERM-1:0] term_in;
   logic [NUM_TERM-1:0] term_out;
   logic [NUM_TERM-1:0] term_oe_n;
   logic card_bus_grant;
   logic pci_lock;
   logic event_output;
   logic [31:0] rd;
   int fail_count = 0;
   int checks_done = 0;
   // expected driver enables when one code fills all seven fields
   logic [6:0] oe_row [16] = '{7'h7f, 7'h00, 7'h33, 7'h7f, 7'h03, 7'h03, 7'h37, 7'h37,
      7'h02, 7'h02, 7'h02, 7'h02, 7'h00, 7'h00, 7'h00, 7'h00};

   // 40 MHz clock
   always #12.5 clk = ~clk;

   mfpr_top i_dut (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .cfg_load_valid, .cfg_load_data,
      .src, .term_in, .term_out, .term_oe_n, .card_bus_grant, .pci_lock, .event_output);
   mfpr_board i_board (.term_out, .term_oe_n, .board_drv, .board_oe, .term_in);

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t register got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_pin(input logic [6:0] got, input logic [6:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t pins got %h expected %h", $time, got, exp);
      end
   endtask : chk_pin

   // one transfer; held until waitrequest is seen low, idle edge first
   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
         input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 40) begin
         fail_count++;
         $display("[FAIL] %0t bus transfer never completed", $time);
      end
   endtask : bus

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask : wr

   task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hf);
      chk_reg(rd, exp);
   endtask : rd_chk

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop();
   end

   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      // rows: each code in every field, sources high then low
      for (int c = 0; c < 16; c++) begin
         wr(10'h230, {4'h0, {7{c[3:0]}}});
         rd_chk(10'h230, {4'h0, {7{c[3:0]}}});
         wr(10'h22c, 32'h1f);
         src <= '1;
         repeat (3) @(posedge clk);
         chk_pin(term_oe_n, oe_row[c]);
         chk_pin(term_out | term_oe_n, c == 14 ? 7'h48 : 7'h7f);
         wr(10'h22c, 32'h0);
         src <= '0;
         repeat (3) @(posedge clk);
         chk_pin(term_out | term_oe_n, oe_row[c]);
      end
      $display("code sweep done");
      // reset in mid-run clears levels and enables and returns routing to 0000_1000
      wr(10'h22c, 32'h1f);
      wr(10'h224, 32'h1f);
      arst_n <= 1'b0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk_pin(term_oe_n, 7'h77);
      chk_pin({5'h0, card_bus_grant, pci_lock}, 7'h03);
      rd_chk(10'h220, 32'h0);
      rd_chk(10'h22c, 32'h0);
      rd_chk(10'h230, 32'h0000_1000);
      rd_chk(10'h224, 32'h0);
      $display("reset test done");
      // input edge on terminal 5 sets status 4 and the event output
      wr(10'h224, 32'h10);
      wr(10'h220, 32'h1f);
      board_oe <= 7'h20;
      repeat (8) @(posedge clk);
      chk_pin({6'h0, event_output}, 7'h01);
      rd_chk(10'h220, 32'h10);
      rd_chk(10'h228, 32'h0f);
      wr(10'h220, 32'h10);
      rd_chk(10'h220, 32'h0);
      chk_pin({6'h0, event_output}, 7'h00);
      $display("event test done");
      // loader value, grant taken high from terminal 5, lock low from terminal 4
      cfg_load_valid <= 1'b1;
      cfg_load_data <= 32'hf122_4567;
      board_drv <= 7'h20;
      board_oe <= 7'h30;
      @(posedge clk);
      cfg_load_valid <= 1'b0;
      rd_chk(10'h230, 32'h0122_4567);
      repeat (8) @(posedge clk);
      chk_pin({5'h0, card_bus_grant, pci_lock}, 7'h02);
      board_oe <= 7'h00;
      $display("loader test done");
      // single lane, reserved bits and unmapped places
      bus(1'b1, 10'h230, 32'h0000_0900, 4'h2);
      rd_chk(10'h230, 32'h0122_0967);
      wr(10'h230, 32'hffff_ffff);
      rd_chk(10'h230, 32'h0fff_ffff);
      wr(10'h22c, 32'h0000_00ea);
      rd_chk(10'h22c, 32'h0a);
      wr(10'h234, 32'hffff_ffff);
      rd_chk(10'h234, 32'h0);
      $display("register test done");
      report_and_stop();
   end
endmodule : testbench
